// >>> shared/pmt_pkg.sv
// Contract
// - An 8-bit count register and an 8-bit period register, both readable and writable.
// - Count driven from oscillator/4 via prescaler: 00 is 1, 01 is 4, 1x is 16.
// - Count runs up from 00h to the period, then returns to 00h next increment.
// - Each match advances a 4-bit postscaler; ratio is postscale field plus one.
// - Postscaler reaching its ratio sets the latched match flag, bit 1 of flags register.
// - Count write, control write and every reset clear prescaler and postscaler counters.
// - A control write leaves the count value unchanged.
// - Every kind of device reset clears the count register to zero.
// - Reset loads the period register with FFh.
// - Run bit at control bit 2 enables counting; zero stops the timer.
// - The match serves as period time base for the capture/compare pulse-width mode.
// - The timer output is offered to the synchronous serial port for its shift clock.
// - The serial port match is taken before the postscaler, pulsing on every match.
package pmt_pkg;

  // Register byte offsets on the bus.
  localparam logic [4:0] PMT_OFF_CONTROL = 5'h00;
  localparam logic [4:0] PMT_OFF_COUNT = 5'h04;
  localparam logic [4:0] PMT_OFF_PERIOD = 5'h08;
  localparam logic [4:0] PMT_OFF_IRQ_FLAGS = 5'h0C;
  localparam logic [4:0] PMT_OFF_IRQ_MASK = 5'h10;
  localparam int PMT_ADDR_WIDTH = 5;

  // Field positions.
  localparam int PMT_PRESCALE_LSB = 0;
  localparam int PMT_RUN_BIT = 2;
  localparam int PMT_POSTSCALE_LSB = 3;
  localparam int PMT_MATCH_FLAG_BIT = 1;

  // Reset values.
  localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hFF;
  localparam logic [7:0] PMT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PMT_MASK_RESET = 8'h00;

  // Timing: oscillator cycles per instruction cycle.
  localparam int PMT_INSTR_DIV = 4;

  // Prescaler ratios minus one, as compared with the prescale counter.
  localparam logic [3:0] PMT_PRE_DIV1 = 4'h0;
  localparam logic [3:0] PMT_PRE_DIV4 = 4'h3;
  localparam logic [3:0] PMT_PRE_DIV16 = 4'hF;

  // AXI responses.
  localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] postscale;
    logic run;
    logic [1:0] prescale;
  } pmt_ctrl_type;

  localparam pmt_ctrl_type PMT_CTRL_RESET = '{postscale: 4'h0, run: 1'h0, prescale: 2'h0};

  typedef enum logic [2:0] {
    PMT_SEL_NONE = 3'h0,
    PMT_SEL_CONTROL = 3'h1,
    PMT_SEL_COUNT = 3'h2,
    PMT_SEL_PERIOD = 3'h3,
    PMT_SEL_FLAGS = 3'h4,
    PMT_SEL_MASK = 3'h5
  } pmt_sel_type;

endpackage : pmt_pkg

// >>> design/pmt_scaler.sv
module pmt_scaler #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic tickIn,
  input wire logic [WIDTH-1:0] ratioMinusOne,
  // Result
  output logic tickOut,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_r;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pmt_scaler: WIDTH must be at least 1.");
    end
  endgenerate

  // Comparing with >= keeps the divider from running a full wrap when the ratio is lowered under the count.
  assign tickOut = tickIn && !clear && (count_r >= ratioMinusOne);
  assign count = count_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (ce) begin
      if (clear || tickOut) begin
        count_r <= '0;
      end else if (tickIn) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

endmodule : pmt_scaler

// >>> design/period_match_timer8.sv
module period_match_timer8
  import pmt_pkg::*;
#(
  parameter int INSTR_DIV = PMT_INSTR_DIV,
  parameter int ADDR_WIDTH = PMT_ADDR_WIDTH
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer outputs
  output logic irq,
  output logic pwmPeriodTick,
  output logic sspTimerTick,
  output logic [7:0] timerCount
);

  localparam int IW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

  if (INSTR_DIV < 2) begin : g_bad_div
    $error("period_match_timer8: INSTR_DIV must be at least 2.");
  end
  if (ADDR_WIDTH < PMT_ADDR_WIDTH) begin : g_bad_addr
    $error("period_match_timer8: ADDR_WIDTH too small for the register map.");
  end

  function automatic pmt_sel_type regSel(input logic [ADDR_WIDTH-1:0] addr);
    logic [PMT_ADDR_WIDTH-1:0] word;
    word = {addr[PMT_ADDR_WIDTH-1:2], 2'h0};
    if ((addr >> PMT_ADDR_WIDTH) != '0) begin
      return PMT_SEL_NONE;
    end
    case (word)
      PMT_OFF_CONTROL: return PMT_SEL_CONTROL;
      PMT_OFF_COUNT: return PMT_SEL_COUNT;
      PMT_OFF_PERIOD: return PMT_SEL_PERIOD;
      PMT_OFF_IRQ_FLAGS: return PMT_SEL_FLAGS;
      PMT_OFF_IRQ_MASK: return PMT_SEL_MASK;
      default: return PMT_SEL_NONE;
    endcase
  endfunction : regSel

  function automatic logic [3:0] prescaleRatio(input logic [1:0] sel);
    case (sel)
      2'h0: return PMT_PRE_DIV1;
      2'h1: return PMT_PRE_DIV4;
      default: return PMT_PRE_DIV16;
    endcase
  endfunction : prescaleRatio

  pmt_ctrl_type ctrl_r;
  logic [7:0] count_r, period_r, flags_r, flags_nxt, mask_r, wData_r, rdByte;
  logic [ADDR_WIDTH-1:0] awAddr_r;
  logic [31:0] rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [3:0] preCount, postCount;
  pmt_sel_type rdSel_r, rdSel, wrSel;
  logic irq_r, matchPulse_r, afterRst_r, awHeld_r, wHeld_r, wStrb0_r, bvalid_r, rvalid_r;
  logic doWrite, wrEn, wrControl, wrCount, wrPeriod, wrFlags, wrMask, scalerClear;
  logic instrTick, preTick, incTick, wrapTick, postTick;

  // Bus write side: address and data are caught independently, the write happens once both are in.
  assign awready = ce && !awHeld_r && !bvalid_r;
  assign wready = ce && !wHeld_r && !bvalid_r;
  assign doWrite = ce && awHeld_r && wHeld_r && !bvalid_r;
  assign wrSel = regSel(awAddr_r);
  assign wrEn = doWrite && wStrb0_r;
  assign wrControl = wrEn && (wrSel == PMT_SEL_CONTROL);
  assign wrCount = wrEn && (wrSel == PMT_SEL_COUNT);
  assign wrPeriod = wrEn && (wrSel == PMT_SEL_PERIOD);
  assign wrFlags = wrEn && (wrSel == PMT_SEL_FLAGS);
  assign wrMask = wrEn && (wrSel == PMT_SEL_MASK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'h0;
      awAddr_r <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld_r <= 1'h1;
        awAddr_r <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld_r <= 1'h0;
      wData_r <= 8'h00;
      wStrb0_r <= 1'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wHeld_r <= 1'h1;
        wData_r <= wdata[7:0];
        wStrb0_r <= wstrb[0];
      end else if (doWrite) begin
        wHeld_r <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'h0;
      bresp_r <= PMT_RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bvalid_r <= 1'h1;
        bresp_r <= (wrSel == PMT_SEL_NONE) ? PMT_RESP_SLVERR : PMT_RESP_OKAY;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'h0;
      end
    end
  end

  // Bus read side: one read in flight, data sampled at the address edge.
  assign arready = ce && !rvalid_r;
  assign rdSel = regSel(araddr);

  always_comb begin
    case (rdSel)
      PMT_SEL_CONTROL: rdByte = {1'h0, ctrl_r};
      PMT_SEL_COUNT: rdByte = count_r;
      PMT_SEL_PERIOD: rdByte = period_r;
      PMT_SEL_FLAGS: rdByte = flags_r;
      PMT_SEL_MASK: rdByte = mask_r;
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= PMT_RESP_OKAY;
      rdSel_r <= PMT_SEL_NONE;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'h1;
        rdata_r <= {24'h00_0000, rdByte};
        rresp_r <= (rdSel == PMT_SEL_NONE) ? PMT_RESP_SLVERR : PMT_RESP_OKAY;
        rdSel_r <= rdSel;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'h0;
      end
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Control and period registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= PMT_CTRL_RESET;
    end else if (ce && wrControl) begin
      ctrl_r <= pmt_ctrl_type'(wData_r[6:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_r <= PMT_PERIOD_RESET;
    end else if (ce && wrPeriod) begin
      period_r <= wData_r;
    end
  end

  // Instruction clock: the divider is never cleared by software, only the scalers are.
  pmt_scaler #(
    .WIDTH(IW)
  ) u_instr_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(1'h0),
    .tickIn(1'h1),
    .ratioMinusOne(IW'(INSTR_DIV - 1)),
    .tickOut(instrTick),
    .count()
  );

  assign scalerClear = wrControl || wrCount;

  pmt_scaler #(
    .WIDTH(4)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(scalerClear),
    .tickIn(instrTick && ctrl_r.run),
    .ratioMinusOne(prescaleRatio(ctrl_r.prescale)),
    .tickOut(preTick),
    .count(preCount)
  );

  // A count or control write in the same cycle suppresses the increment, so software always sees its own value.
  assign incTick = preTick && ctrl_r.run && !scalerClear;
  assign wrapTick = incTick && (count_r == period_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= PMT_COUNT_RESET;
    end else if (ce) begin
      if (wrCount) begin
        count_r <= wData_r;
      end else if (wrapTick) begin
        count_r <= 8'h00;
      end else if (incTick) begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  pmt_scaler #(
    .WIDTH(4)
  ) u_postscaler (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(scalerClear),
    .tickIn(wrapTick),
    .ratioMinusOne(ctrl_r.postscale),
    .tickOut(postTick),
    .count(postCount)
  );

  // Match pulse before the postscaler feeds the PWM time base and the serial port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      matchPulse_r <= 1'h0;
    end else if (ce) begin
      matchPulse_r <= wrapTick;
    end
  end

  assign pwmPeriodTick = matchPulse_r;
  assign sspTimerTick = matchPulse_r;
  assign timerCount = count_r;

  // Interrupt flags: write one to clear, and a new match in the same cycle wins over the clear.
  always_comb begin
    flags_nxt = flags_r;
    if (wrFlags && wData_r[PMT_MATCH_FLAG_BIT]) begin
      flags_nxt[PMT_MATCH_FLAG_BIT] = 1'h0;
    end
    if (postTick) begin
      flags_nxt[PMT_MATCH_FLAG_BIT] = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= PMT_FLAGS_RESET;
      mask_r <= PMT_MASK_RESET;
      irq_r <= 1'h0;
    end else if (ce) begin
      flags_r <= flags_nxt;
      if (wrMask) begin
        mask_r <= wData_r & (8'h01 << PMT_MATCH_FLAG_BIT);
      end
      irq_r <= |(flags_nxt & (wrMask ? wData_r : mask_r));
    end
  end

  assign irq = irq_r;

  // Checks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      afterRst_r <= 1'h0;
    end else begin
      afterRst_r <= 1'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wrap;
    ce && incTick && (count_r == period_r) && !wrCount;
  endsequence
  sequence s_step;
    ce && incTick && (count_r != period_r) && !wrCount;
  endsequence

  a_reset_values: assert property (!afterRst_r |-> (count_r == 8'h00) && (period_r == 8'hFF))
    else $error("Count or period wrong after reset.");
  a_count_wrap: assert property (s_wrap |=> (count_r == 8'h00) && matchPulse_r && sspTimerTick)
    else $error("Count did not wrap to zero with a match pulse.");
  a_count_step: assert property (s_step |=> (count_r == $past(count_r) + 8'h01) && !matchPulse_r)
    else $error("Count did not step by one.");
  a_control_keeps: assert property (ce && wrControl |=> $stable(count_r))
    else $error("Control write changed the count.");
  a_scaler_clear: assert property (ce && scalerClear |=> (preCount == 4'h0) && (postCount == 4'h0))
    else $error("Scaler counters not cleared by a register write.");
  a_stopped_hold: assert property (ce && !ctrl_r.run && !wrCount |=> $stable(count_r) && !matchPulse_r)
    else $error("Stopped timer moved.");
  a_post_ratio: assert property (postCount <= ctrl_r.postscale)
    else $error("Postscaler ran past its ratio.");
  a_flag_set: assert property (ce && postTick |=> flags_r[PMT_MATCH_FLAG_BIT])
    else $error("Postscaler output did not set the match flag.");
  a_flag_sticky: assert property (flags_r[PMT_MATCH_FLAG_BIT] && !wrFlags |=> flags_r[PMT_MATCH_FLAG_BIT])
    else $error("Match flag cleared without a software write.");
  a_ctrl_bit7: assert property (rvalid_r && (rdSel_r == PMT_SEL_CONTROL) |-> !rdata_r[7])
    else $error("Control bit 7 read as one.");
  a_direct_prescale: assert property (ce && instrTick && ctrl_r.run && !scalerClear
                                      && (ctrl_r.prescale == 2'h0) |-> incTick)
    else $error("Prescale 1 missed an instruction tick.");
  a_bresp_hold: assert property (bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("Write response dropped before it was taken.");

endmodule : period_match_timer8

// >>> dv/testbench.sv
module testbench
  import pmt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and enable
  logic clk;
  logic rst_n;
  logic ce;
  // Bus
  logic [4:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [4:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  // Timer outputs
  logic irq;
  logic pwmPeriodTick;
  logic sspTimerTick;
  logic [7:0] timerCount;

  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd_d;
  logic [1:0] rsp;

  period_match_timer8 i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .pwmPeriodTick(pwmPeriodTick),
    .sspTimerTick(sspTimerTick), .timerCount(timerCount));

  always #5 clk = ~clk;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // The whole run needs well under this many cycles; a hang ends here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      $display("BAD at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("BAD at %0t: counted %0d expected %0d", $time, got, exp);
    end
  endtask : check_n

  // Ready is sampled at the falling edge; inputs are stable, so it equals the value seen at the next rising edge.
  task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aDone, wDone, aRdy, wRdy, bDone;
    begin
      aDone = 1'h0;
      wDone = 1'h0;
      bDone = 1'h0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(aDone && wDone)) begin
        @(negedge clk);
        aRdy = awready;
        wRdy = wready;
        @(posedge clk);
        if (aRdy && !aDone) begin
          awvalid <= 1'h0;
          aDone = 1'h1;
        end
        if (wRdy && !wDone) begin
          wvalid <= 1'h0;
          wDone = 1'h1;
        end
      end
      // Holding bready off for two edges makes the response wait while it is not yet taken.
      repeat (2) @(posedge clk);
      bready <= 1'h1;
      while (!bDone) begin
        @(negedge clk);
        bDone = bvalid;
        r = bresp;
        @(posedge clk);
      end
      bready <= 1'h0;
    end
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aRdy, done;
    begin
      aRdy = 1'h0;
      done = 1'h0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      while (!aRdy) begin
        @(negedge clk);
        aRdy = arready;
        @(posedge clk);
      end
      arvalid <= 1'h0;
      rready <= 1'h1;
      while (!done) begin
        @(negedge clk);
        done = rvalid;
        d = rdata;
        r = rresp;
        @(posedge clk);
      end
      rready <= 1'h0;
    end
  endtask : rd

  task automatic wait_tick(output int n);
    begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (sspTimerTick !== 1'h1 && n < 1000);
      check({31'h0, pwmPeriodTick}, 32'h1);
      check({24'h0, timerCount}, 32'h0);
    end
  endtask : wait_tick

  task automatic test_reset();
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4), rd_d, rsp);
      check(rd_d, (i == 2) ? 32'h000000FF : 32'h0);
      check({30'h0, rsp}, {30'h0, PMT_RESP_OKAY});
    end
    check({23'h0, irq, timerCount}, 32'h0);
    $display("Test reset values done");
  endtask : test_reset

  task automatic test_regs();
    wr(PMT_OFF_PERIOD, 8'h5A, rsp);
    check({30'h0, rsp}, {30'h0, PMT_RESP_OKAY});
    rd(PMT_OFF_PERIOD, rd_d, rsp);
    check(rd_d, 32'h5A);
    wstrb <= 4'h0;
    wr(PMT_OFF_PERIOD, 8'h11, rsp);
    wstrb <= 4'hF;
    check({30'h0, rsp}, {30'h0, PMT_RESP_OKAY});
    rd(PMT_OFF_PERIOD, rd_d, rsp);
    check(rd_d, 32'h5A);
    wr(PMT_OFF_COUNT, 8'h33, rsp);
    rd(PMT_OFF_COUNT, rd_d, rsp);
    check(rd_d, 32'h33);
    wr(PMT_OFF_CONTROL, 8'hFB, rsp);
    rd(PMT_OFF_CONTROL, rd_d, rsp);
    check(rd_d, 32'h7B);
    wr(5'h14, 8'h12, rsp);
    check({30'h0, rsp}, {30'h0, PMT_RESP_SLVERR});
    rd(5'h14, rd_d, rsp);
    check({rd_d[29:0], rsp}, {30'h0, PMT_RESP_SLVERR});
    $display("Test register access done");
  endtask : test_regs

  task automatic test_hold();
    wr(PMT_OFF_COUNT, 8'h37, rsp);
    wr(PMT_OFF_CONTROL, 8'h78, rsp);
    rd(PMT_OFF_COUNT, rd_d, rsp);
    check(rd_d, 32'h37);
    repeat (100) @(negedge clk);
    check({24'h0, timerCount}, 32'h37);
    $display("Test stopped count held done");
  endtask : test_hold

  task automatic test_prescale();
    int n;
    int pre;
    wr(PMT_OFF_PERIOD, 8'h02, rsp);
    wr(PMT_OFF_COUNT, 8'h00, rsp);
    for (int p = 0; p < 4; p++) begin
      pre = (p == 0) ? 1 : ((p == 1) ? 4 : 16);
      wr(PMT_OFF_CONTROL, 8'(4 + p), rsp);
      wait_tick(n);
      wait_tick(n);
      check_n(n, 3 * PMT_INSTR_DIV * pre);
    end
    $display("Test prescale and period done");
  endtask : test_prescale

  task automatic test_postscale();
    int nt;
    int n;
    nt = 0;
    n = 0;
    wr(PMT_OFF_CONTROL, 8'h00, rsp);
    wr(PMT_OFF_IRQ_FLAGS, 8'h02, rsp);
    wr(PMT_OFF_IRQ_MASK, 8'h02, rsp);
    wr(PMT_OFF_COUNT, 8'h00, rsp);
    // Ratio three with no prescale: the flag must wait for the third match.
    wr(PMT_OFF_CONTROL, 8'h14, rsp);
    while (irq !== 1'h1 && n < 1000) begin
      @(negedge clk);
      n++;
      if (sspTimerTick === 1'h1) begin
        nt++;
      end
    end
    check_n(nt, 3);
    wr(PMT_OFF_IRQ_MASK, 8'h00, rsp);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h0);
    wr(PMT_OFF_CONTROL, 8'h00, rsp);
    rd(PMT_OFF_IRQ_FLAGS, rd_d, rsp);
    check(rd_d, 32'h2);
    wr(PMT_OFF_IRQ_FLAGS, 8'h02, rsp);
    rd(PMT_OFF_IRQ_FLAGS, rd_d, rsp);
    check(rd_d, 32'h0);
    $display("Test postscale and interrupt done");
  endtask : test_postscale

  task automatic test_freeze_reset();
    logic [7:0] held;
    wr(PMT_OFF_PERIOD, 8'h40, rsp);
    wr(PMT_OFF_CONTROL, 8'h04, rsp);
    repeat (50) @(negedge clk);
    @(posedge clk);
    ce <= 1'h0;
    @(negedge clk);
    held = timerCount;
    repeat (40) @(negedge clk);
    check({24'h0, timerCount}, {24'h0, held});
    check({31'h0, awready}, 32'h0);
    @(posedge clk);
    ce <= 1'h1;
    repeat (20) @(negedge clk);
    @(posedge clk);
    rst_n <= 1'h0;
    @(negedge clk);
    check({23'h0, irq, timerCount}, 32'h0);
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(PMT_OFF_PERIOD, rd_d, rsp);
    check(rd_d, 32'hFF);
    rd(PMT_OFF_CONTROL, rd_d, rsp);
    check(rd_d, 32'h0);
    $display("Test enable freeze and mid-run reset done");
  endtask : test_freeze_reset

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    ce = 1'h1;
    awaddr = 5'h00;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 5'h00;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    test_reset();
    test_regs();
    test_hold();
    test_prescale();
    test_postscale();
    test_freeze_reset();
    finish_test();
  end
endmodule : testbench
